// >>> cssi_pkg.sv
// Package for the core stack, status and interrupt block.
// Assumes a single 20 MHz clock and an asynchronous active-low reset.
package cssi_pkg;
  localparam int          CLK_MHZ        = 20;
  localparam logic [6:0]  ADDR_INDIRECT  = 7'h00;
  localparam logic [6:0]  ADDR_POINTER   = 7'h01;
  localparam logic [6:0]  ADDR_WORK      = 7'h05;
  localparam logic [6:0]  ADDR_PCL       = 7'h06;
  localparam logic [6:0]  ADDR_LOOKUP    = 7'h07;
  localparam logic [6:0]  ADDR_LOOKUPHI  = 7'h08;
  localparam logic [6:0]  ADDR_FLAGS     = 7'h0A;
  localparam logic [6:0]  ADDR_INTCTL    = 7'h0B;
  localparam logic [6:0]  ADDR_GP_FIRST  = 7'h40;
  localparam int          STACK_DEPTH    = 2;
  localparam int          BIT_CARRY      = 0;
  localparam int          BIT_NIBBLE     = 1;
  localparam int          BIT_ZERO       = 2;
  localparam int          BIT_WRAP       = 3;
  localparam int          BIT_HALTED     = 4;
  localparam int          BIT_WDOG       = 5;
  localparam int          BIT_GIE        = 0;
  localparam int          BIT_EIE        = 1;
  localparam int          BIT_TIE        = 2;
  localparam int          BIT_EIF        = 4;
  localparam int          BIT_TIF        = 5;
  localparam logic [7:0]  FLAGS_SW_MASK  = 8'h0F;
  localparam logic [7:0]  INTCTL_MASK    = 8'h37;
  localparam logic [9:0]  VEC_EXT        = 10'h004;
  localparam logic [9:0]  VEC_TIMER      = 10'h008;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [9:0]  RESET_PC       = 10'h000;

  // Arithmetic unit result bundle.
  typedef struct packed {
    logic       valid;
    logic       carryValid;
    logic       carry;
    logic       nibble;
    logic       wrap;
    logic [7:0] result;
  } cssi_alu_s;

  // Flow events reported by the sequencer at an instruction boundary.
  typedef struct packed {
    logic       boundary;
    logic       call;
    logic       ret;
    logic       retIrq;
    logic [9:0] nextPc;
  } cssi_flow_s;

  typedef enum logic [1:0] {
    CSSI_RUN    = 2'b00,
    CSSI_HALTED = 2'b01
  } cssi_state_e;
endpackage

// >>> cssi_core.sv
// Stack, data-memory decode, status flags and interrupt entry of a small core.
// Assumes the instruction sequencer on the same clock drives flow and ALU events.
//
// Behaviour
// RULE_01: Two-entry return stack holds program counter only, hidden from software.
// RULE_02: Call or interrupt pushes program counter; returns restore it from stack.
// RULE_03: Reset points the stack index at the top of the stack.
// RULE_04: Full stack latches interrupt flag but delays service until a return.
// RULE_05: Call on full stack drops the oldest entry, keeping latest two.
// RULE_06: Addresses 40H to 7FH are 64 bytes of general storage.
// RULE_07: Unassigned addresses below 40H read as 00H.
// RULE_08: Working, flag and interrupt control registers sit at 05H, 0AH, 0BH.
// RULE_09: Location 00H accesses byte at pointer; self-pointing reads zero, ignores write.
// RULE_10: Pointer keeps low seven bits; bit 7 reads as one.
// RULE_11: Data bits are settable and clearable singly, directly or indirectly.
// RULE_12: Software writes to flags leave watchdog and halted flags unchanged.
// RULE_13: Bit 0 is carry out or no borrow, also updated by rotates.
// RULE_14: Bit 1 is low nibble carry or no high nibble borrow.
// RULE_15: Bit 2 is set when a result is zero.
// RULE_16: Bit 3 is carry into MSB exclusive-or carry out of MSB.
// RULE_17: Halted flag cleared by reset or watchdog clear, set by halt.
// RULE_18: Watchdog flag cleared by reset, clear or halt; set by time-out; 6,7 zero.
// RULE_19: Entries push only the program counter, never the flags.
// RULE_20: Servicing clears global enable; software may re-enable for nesting.
// RULE_21: Falling pin edge sets bit 4; service calls 04H, clearing flag and enable.
// RULE_22: External and timer interrupts both wake the halted core.
// RULE_23: Timer overflow sets bit 5; service calls 08H, clearing flag and enable.
// RULE_24: Interrupt return also sets global enable; plain return does not.
// RULE_25: Control bits 0,1,2 are global, external and timer enables.
// RULE_26: External interrupt wins over timer when both pend.
// RULE_27: Interrupts are taken only at instruction boundaries; the code also takes them out of the halted state with no boundary.
module cssi_core
  import cssi_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       extIrqPin,
  input  wire logic       timerOverflow,
  input  wire logic       watchdogTimeout,
  input  wire logic       watchdogClearOp,
  input  wire logic       haltOp,
  input  wire cssi_flow_s flow,
  input  wire cssi_alu_s  alu,
  input  wire logic [6:0] memAddr,
  input  wire logic [7:0] memWdata,
  input  wire logic       memWrite,
  input  wire logic       memRead,
  input  wire logic       bitSetOp,
  input  wire logic       bitClearOp,
  input  wire logic [2:0] bitIndex,
  input  wire logic [7:0] lookupHighIn,
  output logic      [7:0] memRdata,
  output logic      [9:0] programCounter,
  output logic            irqTaken,
  output logic            halted,
  output logic            stackFull
);

  // Storage and visible registers.
  logic [7:0]  gpMem [64];
  logic [6:0]  indirectPointer;
  logic [7:0]  workingRegister;
  logic [7:0]  lookupPointer;
  logic [7:0]  flagRegister;
  logic [7:0]  interruptControl;
  logic [9:0]  stackMem [STACK_DEPTH];
  logic [1:0]  stackIndex;
  logic        pinSync1;
  logic        pinSync2;
  logic        pinPrev;
  cssi_state_e state;
  logic [6:0]  effAddr;
  logic        nullAccess;
  logic [7:0]  curByte;
  logic [7:0]  next_byte;
  logic        doWrite;
  logic        extFall;
  logic        extReq;
  logic        timReq;
  logic        takeIrq;
  logic [9:0]  irqVector;
  logic [7:0]  next_intCtl;
  logic        plainBoundary;

  // Resolves the effective address; 00H redirects through the pointer.
  function automatic logic [6:0] eff_addr(input logic [6:0] a, input logic [6:0] p);
    eff_addr = (a == ADDR_INDIRECT) ? p : a;
  endfunction

  assign effAddr    = eff_addr(memAddr, indirectPointer); // RULE_09
  assign nullAccess = (effAddr == ADDR_INDIRECT);         // RULE_09

  // Read decode of the data memory map.
  always_comb begin
    curByte = RESET_BYTE; // RULE_07
    if (effAddr >= ADDR_GP_FIRST) begin
      curByte = gpMem[effAddr[5:0]]; // RULE_06
    end else begin
      unique case (effAddr)
        ADDR_POINTER:  curByte = {1'b1, indirectPointer}; // RULE_10
        ADDR_WORK:     curByte = workingRegister;         // RULE_08
        ADDR_PCL:      curByte = programCounter[7:0];
        ADDR_LOOKUP:   curByte = lookupPointer;
        ADDR_LOOKUPHI: curByte = lookupHighIn;
        ADDR_FLAGS:    curByte = flagRegister;            // RULE_08
        ADDR_INTCTL:   curByte = interruptControl;        // RULE_08
        default:       curByte = RESET_BYTE;              // RULE_07
      endcase
    end
  end

  // Byte to store: plain write or single-bit modify of the current byte.
  always_comb begin
    next_byte = memWdata;
    if (bitSetOp) begin
      next_byte = curByte | (8'h01 << bitIndex);     // RULE_11
    end else if (bitClearOp) begin
      next_byte = curByte & ~(8'h01 << bitIndex);    // RULE_11
    end
  end

  // A self-pointing indirect write is dropped rather than hitting 00H.
  assign doWrite = (memWrite | bitSetOp | bitClearOp) & ~nullAccess; // RULE_09

  // Read data is registered, one cycle after the read strobe.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      memRdata <= RESET_BYTE;
    end else if (memRead) begin
      memRdata <= nullAccess ? RESET_BYTE : curByte; // RULE_09
    end
  end

  // General-purpose storage has no reset, like real RAM.
  always_ff @(posedge ref_clk) begin
    if (doWrite && effAddr >= ADDR_GP_FIRST) begin
      gpMem[effAddr[5:0]] <= next_byte; // RULE_06
    end
  end

  // Pointer, accumulator and table pointer.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      indirectPointer <= 7'h00;
      workingRegister <= RESET_BYTE;
      lookupPointer   <= RESET_BYTE;
    end else if (doWrite) begin
      if (effAddr == ADDR_POINTER) indirectPointer <= next_byte[6:0]; // RULE_10
      if (effAddr == ADDR_WORK)    workingRegister <= next_byte;
      if (effAddr == ADDR_LOOKUP)  lookupPointer   <= next_byte;
    end
  end

  // Flags: ALU results override software; top two flags only by events.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flagRegister <= RESET_BYTE; // RULE_17 RULE_18
    end else begin
      if (doWrite && effAddr == ADDR_FLAGS) begin
        flagRegister[3:0] <= next_byte[3:0]; // RULE_12
      end
      if (alu.valid) begin
        flagRegister[BIT_ZERO] <= (alu.result == RESET_BYTE); // RULE_15
        if (alu.carryValid) begin
          flagRegister[BIT_CARRY]  <= alu.carry;  // RULE_13
          flagRegister[BIT_NIBBLE] <= alu.nibble; // RULE_14
          flagRegister[BIT_WRAP]   <= alu.wrap;   // RULE_16
        end
      end
      if (watchdogClearOp) begin
        flagRegister[BIT_HALTED] <= 1'b0; // RULE_17
        flagRegister[BIT_WDOG]   <= 1'b0; // RULE_18
      end else if (haltOp) begin
        flagRegister[BIT_HALTED] <= 1'b1; // RULE_17
        flagRegister[BIT_WDOG]   <= 1'b0; // RULE_18
      end
      if (watchdogTimeout) flagRegister[BIT_WDOG] <= 1'b1; // RULE_18
      flagRegister[7:6] <= 2'b00; // RULE_18
    end
  end

  // Two-flop synchroniser, then an edge detector on the clean copy.
  // All three reset to the idle high level, so leaving reset cannot fake an edge.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinSync1 <= 1'b1;
      pinSync2 <= 1'b1;
      pinPrev  <= 1'b1;
    end else begin
      pinSync1 <= extIrqPin;
      pinSync2 <= pinSync1;
      pinPrev  <= pinSync2;
    end
  end
  assign extFall = pinPrev & ~pinSync2; // RULE_21

  // A boundary that itself calls or returns is not an entry point: its resume
  // address is not known here, so service waits for the next plain boundary.
  assign plainBoundary = flow.boundary & ~flow.call & ~flow.ret & ~flow.retIrq; // RULE_27

  // Pending requests; the stack-full term holds service off.
  assign extReq  = interruptControl[BIT_GIE] & interruptControl[BIT_EIE]
                 & interruptControl[BIT_EIF];
  assign timReq  = interruptControl[BIT_GIE] & interruptControl[BIT_TIE]
                 & interruptControl[BIT_TIF];
  assign takeIrq = (plainBoundary | (state == CSSI_HALTED)) & (extReq | timReq)
                 & ~stackFull; // RULE_04 RULE_27 RULE_22
  assign irqVector = extReq ? VEC_EXT : VEC_TIMER; // RULE_26
  assign irqTaken  = takeIrq;

  // Next interrupt control: software write, then service or return, and the
  // hardware request flags last, so that a set wins over any software clear.
  always_comb begin
    next_intCtl = interruptControl;
    if (doWrite && effAddr == ADDR_INTCTL) begin
      next_intCtl = next_byte & INTCTL_MASK; // RULE_25
    end
    if (takeIrq) begin
      next_intCtl[BIT_GIE] = 1'b0;             // RULE_20
      if (extReq) next_intCtl[BIT_EIF] = 1'b0; // RULE_21 RULE_26
      else        next_intCtl[BIT_TIF] = 1'b0; // RULE_23
    end else if (flow.boundary && flow.retIrq) begin
      next_intCtl[BIT_GIE] = 1'b1;             // RULE_24
    end
    if (extFall)       next_intCtl[BIT_EIF] = 1'b1; // RULE_21
    if (timerOverflow) next_intCtl[BIT_TIF] = 1'b1; // RULE_23
  end

  // Interrupt control register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      interruptControl <= RESET_BYTE;
    end else begin
      interruptControl <= next_intCtl;
    end
  end

  // Run or halted; an enabled pending interrupt wakes the core unless the stack is full.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= CSSI_RUN;
    end else begin
      unique case (state)
        CSSI_RUN:    if (haltOp) state <= CSSI_HALTED;
        CSSI_HALTED: if (takeIrq || watchdogTimeout) state <= CSSI_RUN; // RULE_22
        default:     state <= CSSI_RUN;
      endcase
    end
  end
  assign halted = (state == CSSI_HALTED);

  // Return stack: index counts used entries, starting empty at the top.
  // Only the program counter is saved; flags must be saved by software.
  // An overflowing call shifts rather than stalls; deep nesting loses the oldest return.
  assign stackFull = (stackIndex == 2'(STACK_DEPTH)); // RULE_04
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stackIndex     <= 2'b00; // RULE_03
      stackMem[0]    <= RESET_PC;
      stackMem[1]    <= RESET_PC;
      programCounter <= RESET_PC;
    end else if (takeIrq) begin
      stackMem[stackIndex[0]] <= flow.boundary ? flow.nextPc : programCounter; // RULE_02 RULE_19
      stackIndex     <= stackIndex + 2'b01;
      programCounter <= irqVector;                                 // RULE_21 RULE_23
    end else if (flow.boundary && flow.call) begin
      if (stackFull) begin
        stackMem[0] <= stackMem[1];                                // RULE_05
        stackMem[1] <= programCounter;                             // RULE_05
      end else begin
        stackMem[stackIndex[0]] <= programCounter;                 // RULE_02 RULE_19
        stackIndex <= stackIndex + 2'b01;
      end
      programCounter <= flow.nextPc;
    end else if (flow.boundary && (flow.ret || flow.retIrq) && stackIndex != 2'b00) begin
      programCounter <= stackMem[stackIndex[0] ^ 1'b1];            // RULE_02 RULE_24
      stackIndex     <= stackIndex - 2'b01;                        // RULE_04
    end else if (flow.boundary) begin
      programCounter <= flow.nextPc;
    end
  end

  // Flag bits 6 and 7 always read zero.
  flag_top_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    flagRegister[7:6] == 2'b00) else $error("flag top bits set"); // RULE_18

  // No acknowledge while the stack is full.
  full_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    stackFull |-> !takeIrq) else $error("irq taken with full stack"); // RULE_04

  // Interrupt entry jumps to its vector and drops the global enable.
  sequence irq_entry_s;
    takeIrq ##1 1'b1;
  endsequence
  entry_vec_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    takeIrq |=> (programCounter == $past(irqVector)) && !interruptControl[BIT_GIE])
    else $error("bad irq entry"); // RULE_20

  // External wins over timer.
  prio_ext_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (takeIrq && extReq && timReq) |=> programCounter == VEC_EXT)
    else $error("priority wrong"); // RULE_26

  // A falling edge on the synchronised pin sets the external flag.
  edge_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (pinPrev && !pinSync2) |=> interruptControl[BIT_EIF]) else $error("edge lost"); // RULE_21

  // Stack index never exceeds its depth.
  index_range_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    stackIndex <= 2'(STACK_DEPTH)) else $error("stack index out of range"); // RULE_01

  // Pointer reads back with bit 7 high.
  ptr_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (memRead && memAddr == ADDR_POINTER) |=> memRdata[7]) else $error("pointer bit7"); // RULE_10

  // Reserved low area reads zero.
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (memRead && memAddr == 7'h20) |=> memRdata == RESET_BYTE) else $error("reserved nonzero"); // RULE_07

  // Interrupt return restores the enable on the next cycle.
  irq_exit_gie_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (flow.boundary && flow.retIrq && !takeIrq) |=> interruptControl[BIT_GIE])
    else $error("irq_exit left enable clear"); // RULE_24

  // Halt sets halted flag and clears watchdog flag.
  halt_flags_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (haltOp && !watchdogClearOp && !watchdogTimeout) |=>
    flagRegister[BIT_HALTED] && !flagRegister[BIT_WDOG]) else $error("halt flags"); // RULE_17

  // Every acknowledge leaves at least one entry on the stack.
  entry_push_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    irq_entry_s |-> stackIndex != 2'b00)
    else $error("irq entry pushed nothing"); // RULE_02

  // A call on a stack with room pushes once and jumps to the target.
  sequence plain_call_s;
    flow.boundary && flow.call && !stackFull && !takeIrq;
  endsequence
  call_push_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    plain_call_s |=> (stackIndex == $past(stackIndex) + 2'b01)
    && (programCounter == $past(flow.nextPc))) else $error("call push wrong"); // RULE_02

  // A call on a full stack keeps the newest entry and the new return address.
  overflow_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (flow.boundary && flow.call && stackFull && !takeIrq) |=> stackFull
    && (stackMem[0] == $past(stackMem[1])) && (stackMem[1] == $past(programCounter)))
    else $error("overflow call lost the newest entry"); // RULE_05

  // A return with entries pops exactly one.
  ret_pop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (flow.boundary && (flow.ret || flow.retIrq) && !flow.call && !takeIrq
     && stackIndex != 2'b00) |=> stackIndex == $past(stackIndex) - 2'b01)
    else $error("return pop wrong"); // RULE_02

  // Service happens only at a plain boundary or out of the halted state.
  boundary_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    takeIrq |-> (plainBoundary || halted))
    else $error("irq taken inside an instruction"); // RULE_27

  // Reads through a self-pointing pointer return zero.
  null_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (memRead && nullAccess) |=> memRdata == RESET_BYTE)
    else $error("null read nonzero"); // RULE_09

  // Software writes to the flags leave the halted and watchdog flags alone.
  sw_flags_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (doWrite && effAddr == ADDR_FLAGS && !haltOp && !watchdogClearOp && !watchdogTimeout)
    |=> flagRegister[BIT_WDOG:BIT_HALTED] == $past(flagRegister[BIT_WDOG:BIT_HALTED]))
    else $error("flag write changed top flags"); // RULE_12

  // A serviced interrupt ends the halted state on the next cycle.
  wake_run_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (halted && takeIrq) |=> !halted) else $error("interrupt did not wake"); // RULE_22

  // A timer overflow always leaves its request flag set.
  timer_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    timerOverflow |=> interruptControl[BIT_TIF]) else $error("timer flag lost"); // RULE_23
endmodule

// >>> cssi_irq_source.sv
// Behavioural model of the external interrupt source on the edge pin.
// Assumes the pin has a pull-up, so it rests high outside a request.
module cssi_irq_source (
  input  wire logic ref_clk,
  output logic      irqPin
);
  timeunit 1ns;
  timeprecision 1ns;

  // The pull-up holds the line high until a request is struck.
  initial begin
    irqPin = 1'b1;
  end

  // Drives one falling edge, held low for a chosen span so slow sources are covered.
  task automatic strike(input int lowCycles);
    @(posedge ref_clk);
    irqPin <= 1'b0;
    repeat (lowCycles) @(posedge ref_clk);
    irqPin <= 1'b1;
  endtask
endmodule

// >>> tb.sv
// Self-checking bench for the stack, data-memory, flag and interrupt block.
// Assumes the external pin is driven by the source model and the bench plays the sequencer.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cssi_pkg::*;

  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [3:0] evt = 4'h0;
  logic [6:0] memAddr = 7'h00;
  logic [7:0] memWdata = 8'h00;
  logic       memWrite = 1'b0;
  logic       memRead = 1'b0;
  logic       bitSetOp = 1'b0;
  logic       bitClearOp = 1'b0;
  logic [2:0] bitIndex = 3'h0;
  cssi_flow_s flow = '0;
  cssi_alu_s  alu = '0;
  logic       extIrqPin;
  logic [7:0] memRdata;
  logic [9:0] programCounter;
  logic       irqTaken;
  logic       halted;
  logic       stackFull;
  int         failures = 0;
  int         checked = 0;
  logic       tk;

  // Half-period toggle gives the 50 ns clock.
  always #25 ref_clk = ~ref_clk;

  cssi_irq_source src (.ref_clk(ref_clk), .irqPin(extIrqPin));

  cssi_core uut (
    .ref_clk(ref_clk), .resetn(resetn), .extIrqPin(extIrqPin),
    .timerOverflow(evt[3]), .watchdogTimeout(evt[2]), .watchdogClearOp(evt[1]),
    .haltOp(evt[0]), .flow(flow), .alu(alu), .memAddr(memAddr), .memWdata(memWdata),
    .memWrite(memWrite), .memRead(memRead), .bitSetOp(bitSetOp), .bitClearOp(bitClearOp),
    .bitIndex(bitIndex), .lookupHighIn(8'hA5), .memRdata(memRdata),
    .programCounter(programCounter), .irqTaken(irqTaken), .halted(halted),
    .stackFull(stackFull)
  );

  // Every comparison is counted; a mismatch is reported at once.
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Register port cycles: one-cycle strobes, read data from the following cycle, held until the next read.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    memAddr <= a; memWdata <= d; memWrite <= 1'b1;
    @(posedge ref_clk);
    memWrite <= 1'b0;
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp, input string msg);
    @(posedge ref_clk);
    memAddr <= a; memRead <= 1'b1;
    @(posedge ref_clk);
    memRead <= 1'b0;
    #5 chk({2'b00, memRdata}, {2'b00, exp}, msg);
  endtask

  task automatic bitop(input logic [6:0] a, input logic [2:0] i, input logic set);
    @(posedge ref_clk);
    memAddr <= a; bitIndex <= i; bitSetOp <= set; bitClearOp <= ~set;
    @(posedge ref_clk);
    bitSetOp <= 1'b0; bitClearOp <= 1'b0;
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk);
    evt[i] <= 1'b1;
    @(posedge ref_clk);
    evt[i] <= 1'b0;
    #5;
  endtask

  task automatic aluop(input logic [3:0] f, input logic [7:0] res);
    @(posedge ref_clk);
    alu <= '{1'b1, f[3], f[2], f[1], f[0], res};
    @(posedge ref_clk);
    alu <= '0;
  endtask

  // Instruction boundary; acceptance is seen in the boundary cycle itself.
  task automatic bnd(input logic c, input logic r, input logic ri, input logic [9:0] pc,
                     output logic taken);
    @(posedge ref_clk);
    flow <= '{1'b1, c, r, ri, pc};
    #5 taken = irqTaken;
    @(posedge ref_clk);
    flow <= '0;
    #5;
  endtask

  task automatic t_map();
    chk({9'h0, stackFull}, 10'h0, "stack after reset");
    rdc(ADDR_FLAGS, 8'h00, "flags reset");
    rdc(ADDR_POINTER, 8'h80, "pointer reset");
    rdc(7'h20, 8'h00, "reserved");
    rdc(ADDR_LOOKUPHI, 8'hA5, "lookup high");
    wr(7'h41, 8'h5A);
    wr(7'h7F, 8'hC3);
    wr(ADDR_WORK, 8'h3C);
    rdc(7'h41, 8'h5A, "ram low");
    rdc(7'h7F, 8'hC3, "ram top");
    rdc(ADDR_WORK, 8'h3C, "work reg");
    wr(ADDR_POINTER, 8'h41);
    rdc(ADDR_POINTER, 8'hC1, "pointer");
    rdc(ADDR_INDIRECT, 8'h5A, "indirect read");
    wr(ADDR_INDIRECT, 8'h66);
    rdc(7'h41, 8'h66, "indirect write");
    bitop(ADDR_INDIRECT, 3'h0, 1'b1);
    bitop(7'h41, 3'h1, 1'b0);
    rdc(7'h41, 8'h65, "bit ops");
    wr(ADDR_POINTER, 8'h00);
    wr(ADDR_INDIRECT, 8'h77);
    rdc(ADDR_INDIRECT, 8'h00, "self pointer");
    $display("test map done");
  endtask

  task automatic t_flags();
    wr(ADDR_FLAGS, 8'hFF);
    rdc(ADDR_FLAGS, 8'h0F, "sw flags");
    aluop(4'b1101, 8'h00);
    rdc(ADDR_FLAGS, 8'h0D, "carry zero wrap");
    aluop(4'b1010, 8'h05);
    rdc(ADDR_FLAGS, 8'h02, "nibble");
    aluop(4'b0000, 8'h00);
    rdc(ADDR_FLAGS, 8'h06, "zero only");
    pulse(2);
    wr(ADDR_FLAGS, 8'h00);
    rdc(ADDR_FLAGS, 8'h20, "timeout kept");
    wr(ADDR_INTCTL, 8'h05);
    pulse(0);
    chk({9'h0, halted}, 10'h1, "halted");
    pulse(3);
    tk = irqTaken;
    for (int n = 0; n < 10 && !tk; n++) begin
      @(posedge ref_clk);
      #5 tk = irqTaken;
    end
    chk({9'h0, tk}, 10'h1, "wake");
    @(posedge ref_clk);
    #5 chk(programCounter, VEC_TIMER, "timer vector");
    chk({9'h0, halted}, 10'h0, "woken");
    rdc(ADDR_INTCTL, 8'h04, "timer entry");
    rdc(ADDR_FLAGS, 8'h10, "halt flags");
    pulse(1);
    rdc(ADDR_FLAGS, 8'h00, "wdt clear");
    $display("test flags done");
  endtask

  task automatic t_irq();
    bnd(1'b0, 1'b0, 1'b1, 10'h050, tk);
    wr(ADDR_INTCTL, 8'h07);
    src.strike(2);
    pulse(3);
    repeat (4) @(posedge ref_clk);
    rdc(ADDR_INTCTL, 8'h37, "pending held");
    bnd(1'b0, 1'b0, 1'b0, 10'h123, tk);
    chk({9'h0, tk}, 10'h1, "taken");
    chk(programCounter, VEC_EXT, "ext first");
    rdc(ADDR_INTCTL, 8'h26, "ext entry");
    bnd(1'b0, 1'b0, 1'b1, 10'h000, tk);
    chk(programCounter, 10'h123, "irq return");
    bnd(1'b0, 1'b0, 1'b0, 10'h124, tk);
    chk(programCounter, VEC_TIMER, "timer second");
    bnd(1'b0, 1'b0, 1'b1, 10'h000, tk);
    rdc(ADDR_INTCTL, 8'h07, "irq exit");
    bnd(1'b1, 1'b0, 1'b0, 10'h200, tk);
    wr(ADDR_INTCTL, 8'h06);
    bnd(1'b0, 1'b1, 1'b0, 10'h000, tk);
    rdc(ADDR_INTCTL, 8'h06, "plain exit");
    $display("test irq done");
  endtask

  task automatic t_stack();
    bnd(1'b0, 1'b0, 1'b0, 10'h010, tk);
    bnd(1'b1, 1'b0, 1'b0, 10'h100, tk);
    bnd(1'b1, 1'b0, 1'b0, 10'h200, tk);
    chk({9'h0, stackFull}, 10'h1, "full");
    wr(ADDR_INTCTL, 8'h03);
    src.strike(6);
    repeat (4) @(posedge ref_clk);
    bnd(1'b0, 1'b0, 1'b0, 10'h201, tk);
    chk({9'h0, tk}, 10'h0, "inhibit");
    rdc(ADDR_INTCTL, 8'h13, "flag latched");
    bnd(1'b1, 1'b0, 1'b0, 10'h300, tk);
    bnd(1'b0, 1'b1, 1'b0, 10'h000, tk);
    chk(programCounter, 10'h201, "newest kept");
    bnd(1'b0, 1'b0, 1'b0, 10'h202, tk);
    chk({9'h0, tk}, 10'h1, "served after ret");
    bnd(1'b0, 1'b0, 1'b1, 10'h000, tk);
    chk(programCounter, 10'h202, "resume");
    bnd(1'b0, 1'b1, 1'b0, 10'h000, tk);
    chk(programCounter, 10'h100, "oldest dropped");
    $display("test stack done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence after an 8-cycle reset.
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    t_map();
    t_flags();
    t_irq();
    t_stack();
    summarize();
  end

  // The tests need well under 2000 cycles; a hang counts as a mismatch.
  initial begin
    #(20000 * 50);
    failures++;
    summarize();
  end
endmodule
